/* cdi_pkg.sv */
/*
 * Shared constants and types of the CPU/DMA interrupt arbitration block:
 * register offsets, field positions, reset values and the pipeline stage enum.
 * Assumes nothing of its surroundings; it is compiled before any module.
 */
package cdi_pkg;

    // Source count and the depth of the enable/mask/flag hazard window.
    localparam int NSRC         = 16;
    localparam int HAZARD_DEPTH = 3;

    // Register byte offsets on the AXI4-Lite slave.
    localparam logic [7:0] OFF_STATUS    = 8'h00;
    localparam logic [7:0] OFF_IEMASK    = 8'h04;
    localparam logic [7:0] OFF_FLAGS     = 8'h08;
    localparam logic [7:0] OFF_EVT_STAT  = 8'h0C;
    localparam logic [7:0] OFF_EVT_MASK  = 8'h10;
    localparam logic [7:0] OFF_DMA_LATCH = 8'h14;
    localparam logic [7:0] OFF_STATE     = 8'h18;

    // Field positions.
    localparam int GIE_BIT      = 13;
    localparam int DMA_MASK_LSB = 16;
    localparam int EVT_CPU_TAKE = 0;
    localparam int EVT_DMA_TAKE = 1;
    localparam int EVT_DMA_DONE = 2;
    localparam int EVT_W        = 3;
    localparam int STATE_STG    = 8;
    localparam int STATE_DMA    = 4;

    // Reset values.
    localparam logic [31:0]     STATUS_RST = 32'h0000_0000;
    localparam logic [31:0]     IEMASK_RST = 32'h0000_0000;
    localparam logic [NSRC-1:0] FLAGS_RST  = 16'h0000;
    localparam logic [EVT_W-1:0] EVT_RST   = 3'h0;

    // AXI responses.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        STG_IDLE   = 2'b00,
        STG_DECODE = 2'b01,
        STG_READ   = 2'b10,
        STG_EXEC   = 2'b11
    } cdi_stage_t;

endpackage

/* cdi_prio_enc.sv */
/*
 * Fixed-priority encoder: the lowest-numbered active request wins.
 * Assumes requests come from logic on the same clock; purely combinational.
 */
`timescale 1ns/1ps
module cdi_prio_enc #(
    parameter int N = 16,
    parameter int W = 4
) (
    // Requests
    input  wire logic [N-1:0] req,
    // Result
    output logic              any,
    output logic [W-1:0]      idx
);

    always_comb begin
        any = 1'b0;
        idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                any = 1'b1;
                idx = W'(i);
            end
        end
    end

endmodule

/* cdi_int_arbiter.sv */
/*
 * CPU/DMA interrupt arbitration: shared flags, global enable, the recognition
 * sequence through decode, read and execute, DMA latching, and an AXI4-Lite
 * register slave with a sticky event interrupt.
 * Assumes the pipeline signals and source events are synchronous to mclk.
 */
// How it works
// - A DMA channel without interrupt sync is untouched by CPU interrupt processing.
// - CPU and DMA accept pending interrupts only at an instruction fetch boundary.
// - Stalled fetch or single-instruction repeat holds off interrupt response.
// - CPU and DMA share one flag set; DMA may clear flags even with GLOBAL_INT_ENABLE off.
// - One source can hit CPU and DMA together; DMA done raises a flag.
// - Taking an interrupt clears global enable; that clear beats a same-cycle load.
// - Status reads within two cycles after recognition already see global enable 0.
// - Decode clears enable and flag, reads stack pointer; read vectors; execute stores.
// - A later status load overwrites the interrupt clear; the routine starts enabled.
// - The repeat-single instruction is uninterruptible, making status logic ops atomic.
// - After clearing global enable, three more instructions may still be interrupted.
// - After setting global enable, interrupts may be held off three instructions.
// - After clearing a CPU mask bit, three more instructions may still take that source.
// - After setting a flag, three instructions may run before it is taken.
// - Return-from-interrupt sets global enable back to 1.
// - DMA-enabled sources are latched for the DMA, flag cleared, DMA notified.
`timescale 1ns/1ps
module cdi_int_arbiter
    import cdi_pkg::*;
#(
    parameter int          NS      = NSRC,
    parameter logic [3:0]  TC_FLAG = 4'hF
) (
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              rstn,
    // AXI4-Lite write
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // CPU pipeline
    input  wire logic              fetchBoundary,
    input  wire logic              fetchStall,
    input  wire logic              repeatSingleInstr,
    input  wire logic              statusLoad,
    input  wire logic [31:0]       statusLoadData,
    input  wire logic              retiExec,
    // Interrupt sources and DMA
    input  wire logic [NS-1:0]     srcEvent,
    input  wire logic              dmaTcDone,
    input  wire logic              dmaReset,
    // Pipeline sequence outputs
    output logic                   globalIntEnable,
    output logic [31:0]            statusWord,
    output logic                   intRecognized,
    output logic                   readStackPointer,
    output logic                   vectorRead,
    output logic                   storeReturnAddr,
    output logic [$clog2(NS)-1:0]  vectorIndex,
    // DMA outputs
    output logic                   dmaNotify,
    output logic [$clog2(NS)-1:0]  dmaSource,
    // Event interrupt
    output logic                   irq
);

    localparam int IW = $clog2(NS);

    function automatic logic [NS-1:0] oneHot(input logic [IW-1:0] i);
        logic [NS-1:0] v;
        v    = '0;
        v[i] = 1'b1;
        return v;
    endfunction

    function automatic logic hitReg(input logic [7:0] a, input logic [7:0] off);
        return a[7:2] == off[7:2];
    endfunction

    function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    cdi_stage_t          stage_q;
    cdi_stage_t          stage_d;
    logic [31:0]         status_q;
    logic [31:0]         ieMask_q;
    logic [NS-1:0]       flags_q;
    logic [NS-1:0]       dmaLatch_q;
    logic [EVT_W-1:0]    evtStat_q;
    logic [EVT_W-1:0]    evtMask_q;
    logic [IW-1:0]       vecIdx_q;
    logic [IW-1:0]       dmaSrc_q;
    logic                dmaNotify_q;
    logic                intRec_q;
    logic                rdSp_q;
    logic                vecRd_q;
    logic                stRet_q;
    logic                irq_q;

    // Hazard history, shifted once per fetch boundary.
    logic [HAZARD_DEPTH-1:0] gieHist_q;
    logic [NS-1:0]           maskHist_q [HAZARD_DEPTH];
    logic [NS-1:0]           flagHist_q [HAZARD_DEPTH];

    // AXI bookkeeping.
    logic        awReady_q;
    logic        wReady_q;
    logic        awHave_q;
    logic        wHave_q;
    logic [7:0]  awAddr_q;
    logic [31:0] wData_q;
    logic [3:0]  wStrb_q;
    logic        bValid_q;
    logic [1:0]  bResp_q;
    logic        arReady_q;
    logic        rValid_q;
    logic [31:0] rData_q;
    logic [1:0]  rResp_q;

    logic awFire;
    logic wFire;
    logic doWrite;
    logic awHave_d;
    logic wHave_d;
    logic bValid_d;
    logic arFire;
    logic rValid_d;
    logic wrStatus;
    logic wrIeMask;
    logic wrFlags;
    logic wrEvtStat;
    logic wrEvtMask;
    logic wrMapped;

    assign awFire    = s_axi_awvalid && awReady_q;
    assign wFire     = s_axi_wvalid && wReady_q;
    assign doWrite   = awHave_q && wHave_q && !bValid_q;
    assign awHave_d  = doWrite ? 1'b0 : (awHave_q | awFire);
    assign wHave_d   = doWrite ? 1'b0 : (wHave_q | wFire);
    assign bValid_d  = doWrite | (bValid_q & ~s_axi_bready);
    assign arFire    = s_axi_arvalid && arReady_q;
    assign rValid_d  = arFire | (rValid_q & ~s_axi_rready);
    assign wrStatus  = doWrite && hitReg(awAddr_q, OFF_STATUS);
    assign wrIeMask  = doWrite && hitReg(awAddr_q, OFF_IEMASK);
    assign wrFlags   = doWrite && hitReg(awAddr_q, OFF_FLAGS);
    assign wrEvtStat = doWrite && hitReg(awAddr_q, OFF_EVT_STAT);
    assign wrEvtMask = doWrite && hitReg(awAddr_q, OFF_EVT_MASK);
    // Every word from the status register up to the state register is mapped.
    assign wrMapped  = awAddr_q[7:2] <= OFF_STATE[7:2];

    // Recognition: enable, CPU mask and flag are seen through the hazard history,
    // so these edits take effect after three fetch boundaries; a flag clear acts at once.
    logic          acceptSlot;
    logic [NS-1:0] cpuPend;
    logic [NS-1:0] dmaPend;
    logic          cpuAny;
    logic          dmaAny;
    logic [IW-1:0] cpuIdx;
    logic [IW-1:0] dmaIdx;
    logic          intTake;
    logic          dmaTake;

    assign acceptSlot = fetchBoundary && !fetchStall && !repeatSingleInstr;
    assign cpuPend    = flags_q & flagHist_q[HAZARD_DEPTH-1]
                      & maskHist_q[HAZARD_DEPTH-1];
    assign dmaPend    = flags_q & flagHist_q[HAZARD_DEPTH-1]
                      & ieMask_q[DMA_MASK_LSB +: NS];
    assign intTake    = acceptSlot && stage_q == STG_IDLE && cpuAny
                      && gieHist_q[HAZARD_DEPTH-1];
    assign dmaTake    = acceptSlot && dmaAny;

    cdi_prio_enc #(.N(NS), .W(IW)) cpuEnc (
        .req (cpuPend),
        .any (cpuAny),
        .idx (cpuIdx)
    );

    cdi_prio_enc #(.N(NS), .W(IW)) dmaEnc (
        .req (dmaPend),
        .any (dmaAny),
        .idx (dmaIdx)
    );

    genvar g;
    generate
        for (g = 0; g < HAZARD_DEPTH; g++) begin : hist
            always_ff @(posedge mclk or negedge rstn) begin
                if (!rstn) begin
                    gieHist_q[g]  <= 1'b0;
                    maskHist_q[g] <= '0;
                    flagHist_q[g] <= '0;
                end else if (intTake) begin
                    // The hardware clear is immediate; only software edits lag.
                    gieHist_q[g]  <= 1'b0;
                    maskHist_q[g] <= (g == 0) ? ieMask_q[NS-1:0] : maskHist_q[g-1];
                    flagHist_q[g] <= (g == 0) ? flags_q : flagHist_q[g-1];
                end else if (fetchBoundary) begin
                    gieHist_q[g]  <= (g == 0) ? status_q[GIE_BIT] : gieHist_q[g-1];
                    maskHist_q[g] <= (g == 0) ? ieMask_q[NS-1:0] : maskHist_q[g-1];
                    flagHist_q[g] <= (g == 0) ? flags_q : flagHist_q[g-1];
                end
            end
        end
    endgenerate

    // Pipeline sequence, one stage per cycle after recognition.
    always_comb begin
        case (stage_q)
            STG_IDLE:   stage_d = intTake ? STG_DECODE : STG_IDLE;
            STG_DECODE: stage_d = STG_READ;
            STG_READ:   stage_d = STG_EXEC;
            STG_EXEC:   stage_d = STG_IDLE;
            default:    stage_d = STG_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            stage_q  <= STG_IDLE;
            intRec_q <= 1'b0;
            rdSp_q   <= 1'b0;
            vecRd_q  <= 1'b0;
            stRet_q  <= 1'b0;
            vecIdx_q <= '0;
        end else begin
            stage_q  <= stage_d;
            intRec_q <= intTake;
            rdSp_q   <= stage_d == STG_DECODE;
            vecRd_q  <= stage_d == STG_READ;
            stRet_q  <= stage_d == STG_EXEC;
            if (intTake) begin
                vecIdx_q <= cpuIdx;
            end
        end
    end

    // Clearing at the recognition edge makes reads in the following cycles see
    // the enable at 0 until a status load, return or status write sets it again.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            status_q <= STATUS_RST;
        end else if (intTake) begin
            status_q[GIE_BIT] <= 1'b0;
        end else if (statusLoad) begin
            status_q <= statusLoadData;
        end else if (retiExec) begin
            status_q[GIE_BIT] <= 1'b1;
        end else if (wrStatus) begin
            status_q <= mergeStrb(status_q, wData_q, wStrb_q);
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ieMask_q  <= IEMASK_RST;
            evtMask_q <= EVT_RST;
        end else begin
            if (wrIeMask) begin
                ieMask_q <= mergeStrb(ieMask_q, wData_q, wStrb_q);
            end
            if (wrEvtMask && wStrb_q[0]) begin
                evtMask_q <= wData_q[EVT_W-1:0];
            end
        end
    end

    // Shared flags: takes clear, new events set, and a set beats any clear.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            flags_q <= FLAGS_RST;
        end else begin
            flags_q <= ((wrFlags ? NS'(mergeStrb(32'(flags_q), wData_q, wStrb_q)) : flags_q)
                     & ~(intTake ? oneHot(cpuIdx) : '0)
                     & ~(dmaTake ? oneHot(dmaIdx) : '0))
                     | srcEvent
                     | (dmaTcDone ? oneHot(TC_FLAG[IW-1:0]) : '0);
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            dmaLatch_q  <= '0;
            dmaNotify_q <= 1'b0;
            dmaSrc_q    <= '0;
        end else begin
            dmaLatch_q  <= (dmaReset ? '0 : dmaLatch_q)
                         | (dmaTake ? oneHot(dmaIdx) : '0);
            dmaNotify_q <= dmaTake;
            if (dmaTake) begin
                dmaSrc_q <= dmaIdx;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            evtStat_q <= EVT_RST;
            irq_q     <= 1'b0;
        end else begin
            evtStat_q <= (evtStat_q & ~((wrEvtStat && wStrb_q[0]) ? wData_q[EVT_W-1:0] : '0))
                       | {dmaTcDone, dmaTake, intTake};
            irq_q     <= |(evtStat_q & evtMask_q);
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            awReady_q <= 1'b0;
            wReady_q  <= 1'b0;
            awHave_q  <= 1'b0;
            wHave_q   <= 1'b0;
            awAddr_q  <= 8'h00;
            wData_q   <= 32'h0000_0000;
            wStrb_q   <= 4'h0;
            bValid_q  <= 1'b0;
            bResp_q   <= RESP_OKAY;
        end else begin
            awHave_q  <= awHave_d;
            wHave_q   <= wHave_d;
            bValid_q  <= bValid_d;
            awReady_q <= !awHave_d && !bValid_d;
            wReady_q  <= !wHave_d && !bValid_d;
            if (awFire) begin
                awAddr_q <= s_axi_awaddr;
            end
            if (wFire) begin
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            if (doWrite) begin
                bResp_q <= wrMapped ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            arReady_q <= 1'b0;
            rValid_q  <= 1'b0;
            rData_q   <= 32'h0000_0000;
            rResp_q   <= RESP_OKAY;
        end else begin
            rValid_q  <= rValid_d;
            arReady_q <= !rValid_d;
            if (arFire) begin
                rResp_q <= RESP_OKAY;
                if (hitReg(s_axi_araddr, OFF_STATUS)) begin
                    rData_q <= status_q;
                end else if (hitReg(s_axi_araddr, OFF_IEMASK)) begin
                    rData_q <= ieMask_q;
                end else if (hitReg(s_axi_araddr, OFF_FLAGS)) begin
                    rData_q <= 32'(flags_q);
                end else if (hitReg(s_axi_araddr, OFF_EVT_STAT)) begin
                    rData_q <= 32'(evtStat_q);
                end else if (hitReg(s_axi_araddr, OFF_EVT_MASK)) begin
                    rData_q <= 32'(evtMask_q);
                end else if (hitReg(s_axi_araddr, OFF_DMA_LATCH)) begin
                    rData_q <= 32'(dmaLatch_q);
                end else if (hitReg(s_axi_araddr, OFF_STATE)) begin
                    rData_q <= 32'({stage_q, 4'(dmaSrc_q), 4'(vecIdx_q)});
                end else begin
                    rData_q <= 32'h0000_0000;
                    rResp_q <= RESP_SLVERR;
                end
            end
        end
    end

    assign s_axi_awready    = awReady_q;
    assign s_axi_wready     = wReady_q;
    assign s_axi_bvalid     = bValid_q;
    assign s_axi_bresp      = bResp_q;
    assign s_axi_arready    = arReady_q;
    assign s_axi_rvalid     = rValid_q;
    assign s_axi_rdata      = rData_q;
    assign s_axi_rresp      = rResp_q;
    assign globalIntEnable  = status_q[GIE_BIT];
    assign statusWord       = status_q;
    assign intRecognized    = intRec_q;
    assign readStackPointer = rdSp_q;
    assign vectorRead       = vecRd_q;
    assign storeReturnAddr  = stRet_q;
    assign vectorIndex      = vecIdx_q;
    assign dmaNotify        = dmaNotify_q;
    assign dmaSource        = dmaSrc_q;
    assign irq              = irq_q;

endmodule

/* cdi_pipe_model.sv */
/* CPU pipeline stand-in that offers fetch boundaries to the arbiter.
   Assumes the single mclk domain and the arbiter's stage pulses. */
`timescale 1ns/1ps
module cdi_pipe_model (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rstn,
    // Bench control and arbiter stages
    input  wire logic stallReq,
    input  wire logic intRecognized,
    input  wire logic storeReturnAddr,
    // Fetch status
    output logic      fetchBoundary,
    output logic      fetchStall
);
    logic serving_q;
    // No fetch in the read and execute stages of a taken interrupt.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            serving_q <= 1'b0;
        end else if (intRecognized) begin
            serving_q <= 1'b1;
        end else if (storeReturnAddr) begin
            serving_q <= 1'b0;
        end
    end
    assign fetchStall    = stallReq;
    assign fetchBoundary = rstn && !serving_q && !stallReq;
endmodule

/* cdi_int_arbiter_sva.sv */
/* Concurrent checks on the arbiter's ports.
   Assumes one mclk domain; bound onto cdi_int_arbiter. */
`timescale 1ns/1ps
module cdi_int_arbiter_chk
    import cdi_pkg::*;
(
    // Clock and reset
    input wire logic        mclk,
    input wire logic        rstn,
    // Pipeline inputs
    input wire logic        fetchBoundary,
    input wire logic        fetchStall,
    input wire logic        repeatSingleInstr,
    input wire logic        statusLoad,
    input wire logic [31:0] statusLoadData,
    input wire logic        retiExec,
    // Sequence outputs
    input wire logic        globalIntEnable,
    input wire logic        intRecognized,
    input wire logic        readStackPointer,
    input wire logic        vectorRead,
    input wire logic        storeReturnAddr,
    input wire logic        dmaNotify
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    property p_seq; intRecognized |-> readStackPointer ##1 (vectorRead && !intRecognized)
        ##1 (storeReturnAddr && !intRecognized); endproperty
    a_seq: assert property (p_seq) else $error("stage walk broken");
    property p_gie; intRecognized |-> !globalIntEnable; endproperty
    a_gie: assert property (p_gie) else $error("enable not cleared in decode");
    property p_fb; intRecognized |-> $past(fetchBoundary); endproperty
    a_fb: assert property (p_fb) else $error("take off a fetch boundary");
    property p_stall; fetchStall |=> !intRecognized && !dmaNotify; endproperty
    a_stall: assert property (p_stall) else $error("take while stalled");
    property p_rpt; repeatSingleInstr |=> !intRecognized && !dmaNotify; endproperty
    a_rpt: assert property (p_rpt) else $error("take inside repeat");
    property p_load; statusLoad |=> intRecognized ||
        (globalIntEnable == $past(statusLoadData[GIE_BIT])); endproperty
    a_load: assert property (p_load) else $error("status load lost");
    property p_reti; retiExec && !statusLoad |=> globalIntEnable || intRecognized; endproperty
    a_reti: assert property (p_reti) else $error("return left enable low");
    property p_rose; $rose(globalIntEnable) |-> !intRecognized [*3]; endproperty
    a_rose: assert property (p_rose) else $error("take inside enable window");
    property p_dma; dmaNotify |-> $past(fetchBoundary) && !$past(fetchStall); endproperty
    a_dma: assert property (p_dma) else $error("dma take off boundary");
endmodule

bind cdi_int_arbiter cdi_int_arbiter_chk u_chk (.*);

/* tb.sv */
/* Self-checking bench for cdi_int_arbiter with the pipeline stand-in.
   Assumes the checker is bound and the register map of cdi_pkg. */
`timescale 1ns/1ps
module tb;
    import cdi_pkg::*;
    typedef struct packed {
        logic [15:0] src;
        logic        tc;
        logic [31:0] mask;
        logic        global_int_enable;
        logic [4:0]  cpu;
        logic [4:0]  dma;
        logic [15:0] flags;
    } cdi_row_t;
    logic        mclk, rstn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, stallReq, repeatSingleInstr;
    logic        statusLoad, retiExec, dmaTcDone, dmaReset, globalIntEnable, irq;
    logic        fetchBoundary, fetchStall, intRecognized, readStackPointer;
    logic        vectorRead, storeReturnAddr, dmaNotify;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, statusLoadData, statusWord, rd;
    logic [1:0]  bresp, rresp, rs;
    logic [15:0] srcEvent;
    logic [3:0]  vectorIndex, dmaSource;
    logic [4:0]  cpuSeen, dmaSeen;
    int          failures, checks;
    cdi_row_t    rows [7];

    cdi_int_arbiter u_cdi_int_arbiter (
        .mclk(mclk), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .fetchBoundary(fetchBoundary), .fetchStall(fetchStall),
        .repeatSingleInstr(repeatSingleInstr), .statusLoad(statusLoad),
        .statusLoadData(statusLoadData), .retiExec(retiExec), .srcEvent(srcEvent),
        .dmaTcDone(dmaTcDone), .dmaReset(dmaReset), .globalIntEnable(globalIntEnable),
        .statusWord(statusWord), .intRecognized(intRecognized),
        .readStackPointer(readStackPointer), .vectorRead(vectorRead),
        .storeReturnAddr(storeReturnAddr), .vectorIndex(vectorIndex),
        .dmaNotify(dmaNotify), .dmaSource(dmaSource), .irq(irq)
    );
    cdi_pipe_model u_cdi_pipe_model (
        .mclk(mclk), .rstn(rstn), .stallReq(stallReq), .intRecognized(intRecognized),
        .storeReturnAddr(storeReturnAddr), .fetchBoundary(fetchBoundary),
        .fetchStall(fetchStall)
    );

    always #5 mclk = ~mclk;
    // Latches take pulses for later checks.
    always @(posedge mclk) begin
        if (intRecognized === 1'b1) cpuSeen <= {1'b1, vectorIndex};
        if (dmaNotify === 1'b1) dmaSeen <= {1'b1, dmaSource};
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task give_verdict;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task axiWr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
        for (n = 0; n < 40 && bvalid !== 1'b1; n++) begin
            @(posedge mclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        rs = bresp;
        if (n >= 40) failures++;
    endtask
    task axiRd(input logic [7:0] a);
        int n;
        @(posedge mclk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        for (n = 0; n < 40 && rvalid !== 1'b1; n++) begin
            @(posedge mclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        rd = rdata;
        rs = rresp;
        if (n >= 40) failures++;
    endtask
    // Four edges let the enable history settle.
    task arm(input logic [31:0] mask, input logic global_int_enable);
        axiWr(OFF_STATUS, 32'h0);
        axiWr(OFF_FLAGS, 32'h0);
        axiWr(OFF_IEMASK, mask);
        axiWr(OFF_STATUS, 32'(global_int_enable) << GIE_BIT);
        repeat (4) @(posedge mclk);
        {cpuSeen, dmaSeen} <= 10'h0;
    endtask
    task pulse(input logic [15:0] src, input logic tc);
        srcEvent <= src;
        dmaTcDone <= tc;
        @(posedge mclk);
        srcEvent <= 16'h0;
        dmaTcDone <= 1'b0;
    endtask

    initial begin
        #100000;
        failures++;
        give_verdict;
    end
    initial begin
        {mclk, rstn, awvalid, wvalid, bready, arvalid, rready, stallReq} = '0;
        {repeatSingleInstr, statusLoad, retiExec, dmaTcDone, dmaReset} = '0;
        {awaddr, araddr, wdata, statusLoadData, srcEvent} = '0;
        rows = '{'{16'h0001, 1'b0, 32'h00000001, 1'b1, 5'h10, 5'h00, 16'h0000},
                 '{16'h0006, 1'b0, 32'h0000FFFF, 1'b1, 5'h11, 5'h00, 16'h0004},
                 '{16'h0030, 1'b0, 32'h00000020, 1'b1, 5'h15, 5'h00, 16'h0010},
                 '{16'h0008, 1'b0, 32'h00080008, 1'b1, 5'h13, 5'h13, 16'h0000},
                 '{16'h0004, 1'b0, 32'h00040004, 1'b0, 5'h00, 5'h12, 16'h0000},
                 '{16'h0000, 1'b1, 32'h00008000, 1'b1, 5'h1F, 5'h00, 16'h0000},
                 '{16'h0001, 1'b0, 32'h00000000, 1'b1, 5'h00, 5'h00, 16'h0001}};
        repeat (8) @(posedge mclk);
        rstn <= 1'b1;
        axiRd(OFF_STATUS);
        chk(rd, STATUS_RST);
        axiRd(OFF_IEMASK);
        chk(rd, IEMASK_RST);
        axiRd(8'h1C);
        chk({rs, rd}, {RESP_SLVERR, 32'h0});
        axiWr(8'h1C, 32'h1);
        chk(rs, RESP_SLVERR);
        axiWr(OFF_EVT_MASK, 32'h1);
        foreach (rows[i]) begin
            arm(rows[i].mask, rows[i].global_int_enable);
            pulse(rows[i].src, rows[i].tc);
            repeat (12) @(posedge mclk);
            chk(cpuSeen, rows[i].cpu);
            chk(dmaSeen, rows[i].dma);
            axiRd(OFF_FLAGS);
            chk(rd, {16'h0, rows[i].flags});
        end
        for (int k = 0; k < 2; k++) begin
            arm(32'h00010001, 1'b1);
            {stallReq, repeatSingleInstr} <= k ? 2'b01 : 2'b10;
            pulse(16'h0001, 1'b0);
            repeat (10) @(posedge mclk);
            chk({cpuSeen, dmaSeen}, 10'h0);
            {stallReq, repeatSingleInstr} <= 2'b00;
            repeat (10) @(posedge mclk);
            chk({cpuSeen, dmaSeen}, {5'h10, 5'h10});
        end
        arm(32'h00000001, 1'b1);
        statusLoadData <= 32'h2000;
        statusLoad <= 1'b1;
        pulse(16'h0001, 1'b0);
        for (int n = 0; n < 20 && intRecognized !== 1'b1; n++) @(posedge mclk);
        chk({intRecognized, globalIntEnable}, 2'b10);
        statusLoad <= 1'b0;
        repeat (3) @(posedge mclk);
        chk(globalIntEnable, 1'b1);
        axiWr(OFF_STATUS, 32'h0);
        retiExec <= 1'b1;
        @(posedge mclk);
        retiExec <= 1'b0;
        repeat (2) @(posedge mclk);
        chk(globalIntEnable, 1'b1);
        axiRd(OFF_EVT_STAT);
        chk(rd, 32'h7);
        chk(irq, 1'b1);
        axiWr(OFF_EVT_MASK, 32'h0);
        repeat (2) @(posedge mclk);
        chk(irq, 1'b0);
        axiWr(OFF_EVT_MASK, 32'h1);
        axiWr(OFF_EVT_STAT, 32'h7);
        repeat (2) @(posedge mclk);
        axiRd(OFF_EVT_STAT);
        chk({irq, rd}, 33'h0);
        dmaReset <= 1'b1;
        @(posedge mclk);
        dmaReset <= 1'b0;
        axiRd(OFF_DMA_LATCH);
        chk(rd, 32'h0);
        give_verdict;
    end
endmodule
